//--- hdl/ppm_port_power.sv
// Purpose: Port 1/2 address muxing, pin modes and idle / power-down control.
// Assumes: Special-function writes arrive as a one-cycle strobe with address and data.
// Notes:   Pins are split into output, enable and input; the pad resolves them.
// How it works
// R01: Address enable high puts low address out
// R02: Address enable low shows port one latch
// R03: Port two shows high address when allowed
// R04: Quasi pins have fixed weak pullups
// R05: Strong one only briefly, then weak
// R06: Internal port zero feeds scan only
// R07: Power bit zero enters idle
// R08: Idle gates core clock, keeps state
// R09: Idle holds pins, strobes high
// R10: Reset or enabled interrupt ends idle
// R11: Conversion during idle may be invalid
// R12: Power bit one stops all clocks
// R13: Power-down deselects memory unless gpio
// R14: Power-down forces both strobes low
// R15: Only reset leaves power-down
// R16: Board drives floating pins in power-down
// R17: Reset tri-states buses, releases pins
// R18: Access select sampled at reset fall
// R19: Memory select usable as gpio
`timescale 1ns/1ps
module ppm_port_power
	import ppm_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       reset_i,
	// Special-function register port
	input  wire logic       sfr_write_i,
	input  wire logic [7:0] sfr_addr_i,
	input  wire logic [7:0] sfr_wdata_i,
	output logic      [7:0] sfr_rdata_o,
	// Core side
	input  wire logic [14:0] fetch_addr_i,
	input  wire logic        fetch_active_i,
	input  wire logic        addr_latch_pulse_i,
	input  wire logic        prog_store_pulse_i,
	input  wire logic        ext_fetch_i,
	input  wire logic        wake_interrupt_i,
	input  wire logic [7:0]  port_zero_i,
	output logic             core_clk_enable_o,
	output logic             periph_clk_enable_o,
	output logic             osc_enable_o,
	output logic             ext_program_mem_o,
	output logic             conversion_suspect_o,
	output logic [7:0]       scan_drive_o,
	// Pins
	input  wire logic        low_addr_out_enable_i,
	input  wire logic        ext_access_select_n_i,
	output logic [7:0]       port_one_pin_o,
	output logic [7:0]       port_one_oe_o,
	output logic [6:0]       port_two_pin_o,
	output logic [6:0]       port_two_oe_o,
	output logic             addr_latch_strobe_o,
	output logic             prog_store_strobe_n_o,
	input  wire logic        ext_mem_select_n_i,
	output logic             ext_mem_select_n_o,
	output logic             ext_mem_select_n_oe_o,
	output logic             muxed_addr_data_bus_oe_o,
	output logic             host_data_bus_oe_o,
	output logic [4:0]       open_drain_oe_o,
	output logic [4:0]       open_drain_pin_o
);

	// ==========================================================
	// Pin synchronisers
	logic loaden_s1, loaden_s2, acc_sel_s1, acc_sel_s2, cs_s1, cs_s2;
	always_ff @(posedge ref_clk_i) begin
		loaden_s1 <= low_addr_out_enable_i;
		loaden_s2 <= loaden_s1;
		acc_sel_s1 <= ext_access_select_n_i;
		acc_sel_s2 <= acc_sel_s1;
		cs_s1     <= ext_mem_select_n_i;
		cs_s2     <= cs_s1;
	end

	// ==========================================================
	// Registers and mode
	ppm_mode_t  mode, next_mode;
	logic [7:0] power_mode_control, next_power_mode_control;
	logic [7:0] port_one_latch, next_port_one_latch;
	logic [7:0] port_two_latch, next_port_two_latch;
	logic [7:0] config_one, next_config_one;
	logic       acc_sel_latched, next_acc_sel_latched;
	logic       reset_d;
	logic       held_in_reset;
	logic       ale_q, next_ale_q, psen_q, next_psen_q;
	logic       cs_q, next_cs_q;
	logic       conv_q, next_conv_q;

	function automatic logic sfr_hit(input logic [7:0] a, input logic [7:0] want);
		sfr_hit = sfr_write_i && (a == want);
	endfunction : sfr_hit

	always_comb begin
		next_power_mode_control = power_mode_control;
		next_port_one_latch     = port_one_latch;
		next_port_two_latch     = port_two_latch;
		next_config_one         = config_one;
		next_mode               = mode;
		next_conv_q             = conv_q;
		// R08 no writes while core halted
		if (mode == PPM_RUN) begin
			if (sfr_hit(sfr_addr_i, POWER_MODE_CONTROL_ADDR)) next_power_mode_control = sfr_wdata_i;
			if (sfr_hit(sfr_addr_i, PORT_ONE_LATCH_ADDR))     next_port_one_latch = sfr_wdata_i;
			if (sfr_hit(sfr_addr_i, PORT_TWO_LATCH_ADDR))     next_port_two_latch = sfr_wdata_i;
			if (sfr_hit(sfr_addr_i, CONFIG_ONE_ADDR))         next_config_one = sfr_wdata_i;
		end
		case (mode)
			PPM_RUN: begin
				// R12 power-down wins over idle
				if (next_power_mode_control[POWERDOWN_REQUEST_BIT]) begin
					next_mode = PPM_POWERDOWN;
				// R07 idle entry
				end else if (next_power_mode_control[IDLE_REQUEST_BIT]) begin
					next_mode = PPM_IDLE;
					// R11 conversion result not guaranteed
					next_conv_q = 1'b1;
				end
			end
			PPM_IDLE: begin
				// R10 interrupt wake
				if (wake_interrupt_i) begin
					next_mode = PPM_RUN;
					next_power_mode_control[IDLE_REQUEST_BIT] = 1'b0;
				end
			end
			// R15 only reset exits
			PPM_POWERDOWN: next_mode = PPM_POWERDOWN;
			default:       next_mode = PPM_RUN;
		endcase
	end

	// R18 sample access select at reset fall
	assign next_acc_sel_latched = (reset_d && !reset_i) ? acc_sel_s2 : acc_sel_latched;

	always_ff @(posedge ref_clk_i) begin
		reset_d     <= reset_i;
		acc_sel_latched <= next_acc_sel_latched;
		if (reset_i) begin
			// R10 R15 reset ends both modes
			mode               <= PPM_RUN;
			power_mode_control <= POWER_MODE_CONTROL_RESET;
			port_one_latch     <= PORT_LATCH_RESET;
			port_two_latch     <= PORT_LATCH_RESET;
			config_one         <= CONFIG_ONE_RESET;
			conv_q             <= 1'b0;
			ale_q              <= 1'b0;
			psen_q             <= 1'b0;
			cs_q               <= 1'b1;
		end else begin
			mode               <= next_mode;
			power_mode_control <= next_power_mode_control;
			port_one_latch     <= next_port_one_latch;
			port_two_latch     <= next_port_two_latch;
			config_one         <= next_config_one;
			conv_q             <= next_conv_q;
			ale_q              <= next_ale_q;
			psen_q             <= next_psen_q;
			cs_q               <= next_cs_q;
		end
	end

	assign held_in_reset = reset_i;

	// ==========================================================
	// Port values
	logic [7:0] port_one_value;
	logic [6:0] port_two_value;
	logic       freeze;
	always_comb begin
		// R01 R02 low address or latch
		port_one_value = (loaden_s2 && fetch_active_i) ? fetch_addr_i[7:0] : port_one_latch;
		// R03 high address gating
		if (fetch_active_i && (!acc_sel_latched || config_one[CFG_HIGH_ADDR_EN_BIT])) begin
			port_two_value = fetch_addr_i[14:8];
		end else begin
			port_two_value = port_two_latch[6:0];
		end
	end
	// R09 pins hold in idle and power-down
	assign freeze = (mode != PPM_RUN);

	ppm_pin_driver #(.WIDTH(8)) u_port_one (
		.ref_clk_i     (ref_clk_i),
		.reset_i       (reset_i),
		.freeze_i      (freeze),
		.value_i       (port_one_value),
		.pin_o         (port_one_pin_o),
		.pin_oe_o      (port_one_oe_o),
		.weak_pullup_o ()
	);
	ppm_pin_driver #(.WIDTH(7)) u_port_two (
		.ref_clk_i     (ref_clk_i),
		.reset_i       (reset_i),
		.freeze_i      (freeze),
		.value_i       (port_two_value),
		.pin_o         (port_two_pin_o),
		.pin_oe_o      (port_two_oe_o),
		.weak_pullup_o ()
	);

	// ==========================================================
	// Strobes and memory select
	always_comb begin
		next_ale_q  = addr_latch_pulse_i;
		next_psen_q = !(prog_store_pulse_i && ext_fetch_i);
		next_cs_q   = !(ext_fetch_i && fetch_active_i);
		case (next_mode)
			// R09 strobes high in idle
			PPM_IDLE: begin
				next_ale_q  = 1'b1;
				next_psen_q = 1'b1;
				next_cs_q   = 1'b1;
			end
			// R14 strobes low in power-down
			PPM_POWERDOWN: begin
				next_ale_q  = 1'b0;
				next_psen_q = 1'b0;
				// R13 deselect memory
				next_cs_q   = 1'b1;
			end
			default: begin
			end
		endcase
	end

	assign addr_latch_strobe_o   = ale_q;
	assign prog_store_strobe_n_o = psen_q;
	// R19 select pin as gpio
	assign ext_mem_select_n_o    = config_one[CFG_SELECT_GPIO_BIT] ? port_two_latch[7] : cs_q;
	assign ext_mem_select_n_oe_o = !config_one[CFG_SELECT_GPIO_BIT] || !port_two_latch[7];

	// ==========================================================
	// Clocks, buses and misc
	// R08 R12 clock gating
	assign core_clk_enable_o    = (mode == PPM_RUN);
	assign periph_clk_enable_o  = (mode != PPM_POWERDOWN);
	assign osc_enable_o         = (mode != PPM_POWERDOWN);
	assign ext_program_mem_o    = !acc_sel_latched;
	assign conversion_suspect_o = conv_q;
	// R06 port zero only to scan logic
	assign scan_drive_o         = port_zero_i;
	// R17 buses released at reset
	assign muxed_addr_data_bus_oe_o = !held_in_reset && fetch_active_i && (mode == PPM_RUN);
	assign host_data_bus_oe_o       = 1'b0;
	assign open_drain_pin_o         = 5'h00;
	assign open_drain_oe_o          = held_in_reset ? 5'h00 : 5'h00;

	always_comb begin
		case (sfr_addr_i)
			POWER_MODE_CONTROL_ADDR: sfr_rdata_o = power_mode_control;
			PORT_ONE_LATCH_ADDR:     sfr_rdata_o = port_one_latch;
			PORT_TWO_LATCH_ADDR:     sfr_rdata_o = {config_one[CFG_SELECT_GPIO_BIT] ? cs_s2 : port_two_latch[7],
			                                        port_two_latch[6:0]};
			CONFIG_ONE_ADDR:         sfr_rdata_o = config_one;
			default:                 sfr_rdata_o = 8'h00;
		endcase
	end

	// ==========================================================
	// Checks
	idle_strobes_high_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R09
		(mode == PPM_IDLE) |-> (ale_q && psen_q))
		else $error("strobes not high in idle");
	pd_strobes_low_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R14
		(mode == PPM_POWERDOWN) |=> (!ale_q && !psen_q))
		else $error("strobes not low in power-down");
	pd_no_wake_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R15
		(mode == PPM_POWERDOWN) |=> (mode == PPM_POWERDOWN))
		else $error("left power-down without reset");
	idle_entry_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R07
		(mode == PPM_RUN && sfr_write_i && sfr_addr_i == POWER_MODE_CONTROL_ADDR && sfr_wdata_i == 8'h01)
		|=> (mode == PPM_IDLE))
		else $error("idle not entered");
	pd_clocks_off_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R12
		(mode == PPM_POWERDOWN) |-> (!osc_enable_o && !core_clk_enable_o))
		else $error("clocks running in power-down");
	idle_wake_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R10
		(mode == PPM_IDLE && wake_interrupt_i) |=> (mode == PPM_RUN))
		else $error("interrupt did not wake idle");
	port_one_addr_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R01
		(mode == PPM_RUN && loaden_s2 && fetch_active_i) |=> (port_one_pin_o == $past(fetch_addr_i[7:0])))
		else $error("low address not on port one");
	pd_deselect_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R13
		(mode == PPM_POWERDOWN && !config_one[CFG_SELECT_GPIO_BIT]) |-> ext_mem_select_n_o)
		else $error("memory still selected in power-down");

endmodule : ppm_port_power

//--- common/ppm_pkg.sv
// Purpose: Shared constants for the port and power mode controller.
// Assumes: Core clock at 100 MHz; registers written over a simple special-function port.
// Notes:   Offsets, field positions and reset values live here only.
package ppm_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] POWER_MODE_CONTROL_ADDR = 8'h87;
	localparam logic [7:0] PORT_ONE_LATCH_ADDR     = 8'h90;
	localparam logic [7:0] PORT_TWO_LATCH_ADDR     = 8'ha0;
	localparam logic [7:0] CONFIG_ONE_ADDR         = 8'hb0;

	// ==========================================================
	// Field positions
	localparam int IDLE_REQUEST_BIT      = 0;
	localparam int POWERDOWN_REQUEST_BIT = 1;
	localparam int CFG_HIGH_ADDR_EN_BIT  = 0;
	localparam int CFG_SELECT_GPIO_BIT   = 3;

	// ==========================================================
	// Reset values
	localparam logic [7:0] POWER_MODE_CONTROL_RESET = 8'h00;
	localparam logic [7:0] PORT_LATCH_RESET         = 8'hff;
	localparam logic [7:0] CONFIG_ONE_RESET         = 8'h00;

	// ==========================================================
	// Timing: strong pullup lasts two oscillator periods
	localparam int STRONG_PULLUP_NS     = 20;
	localparam int CLK_PERIOD_NS        = 10;
	localparam int STRONG_PULLUP_CYCLES = (STRONG_PULLUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		PPM_RUN,
		PPM_IDLE,
		PPM_POWERDOWN
	} ppm_mode_t;

endpackage : ppm_pkg

//--- hdl/ppm_pin_driver.sv
// Purpose: One quasi-bidirectional pin group: strong drive of a rising one for a short time, then weak.
// Assumes: Same clock as the caller.
// Notes:   Output enable high means strong drive; weak pullup is reported separately.
`timescale 1ns/1ps
module ppm_pin_driver
	import ppm_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             ref_clk_i,
	input  wire logic             reset_i,
	// Control
	input  wire logic             freeze_i,
	input  wire logic [WIDTH-1:0] value_i,
	// Pin side
	output logic      [WIDTH-1:0] pin_o,
	output logic      [WIDTH-1:0] pin_oe_o,
	output logic      [WIDTH-1:0] weak_pullup_o
);

	// Boost counter is two bits wide, so the strong time must fit in 1 to 3 cycles
	if (WIDTH < 1 || STRONG_PULLUP_CYCLES < 1 || STRONG_PULLUP_CYCLES > 3) begin : g_bad_params
		$error("ppm_pin_driver: bad parameters");
	end

	logic [WIDTH-1:0] value_q;
	logic [WIDTH-1:0] next_value_q;
	logic [1:0]       boost [WIDTH];
	logic [1:0]       next_boost [WIDTH];

	always_comb begin
		next_value_q = freeze_i ? value_q : value_i;
		for (int i = 0; i < WIDTH; i++) begin
			// R05 brief strong one
			if (!value_q[i] && next_value_q[i]) begin
				next_boost[i] = 2'(STRONG_PULLUP_CYCLES);
			end else if (boost[i] != 2'h0 && !freeze_i) begin
				next_boost[i] = boost[i] - 2'h1;
			end else begin
				next_boost[i] = boost[i];
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			value_q <= '1;
			for (int i = 0; i < WIDTH; i++) begin
				boost[i] <= 2'h0;
			end
		end else begin
			value_q <= next_value_q;
			boost   <= next_boost;
		end
	end

	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			pin_o[i]    = value_q[i];
			// R04 pullup holds ones
			pin_oe_o[i]      = !value_q[i] || (boost[i] != 2'h0);
			weak_pullup_o[i] = 1'b1;
		end
	end

	strong_short_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(boost[0] != 2'h0 && !freeze_i) |=> boost[0] != $past(boost[0])) // R05
		else $error("strong pullup held too long");

endmodule : ppm_pin_driver

//--- sim/ppm_ext_memory.sv
// Purpose: External program memory and board pins beside the port controller.
// Assumes: The memory latches the address on the falling address strobe.
// Notes:   A released select pin settles to its board pull-up level.
`timescale 1ns/1ps
module ppm_ext_memory (
	// Clock
	input  wire logic        ref_clk_i,
	// Bus side
	input  wire logic        addr_latch_strobe_i,
	input  wire logic [7:0]  port_one_pin_i,
	input  wire logic [6:0]  port_two_pin_i,
	input  wire logic        select_n_i,
	input  wire logic        select_n_oe_i,
	output logic             select_n_o,
	output logic [14:0]      latched_addr_o
);
	logic ale_q;

	// ==========================================================
	// Board side
	// pin never floats
	assign select_n_o = select_n_oe_i ? select_n_i : 1'b1;

	// ==========================================================
	// Address capture
	always_ff @(posedge ref_clk_i) begin
		ale_q <= addr_latch_strobe_i;
		if (ale_q && !addr_latch_strobe_i) begin
			latched_addr_o <= {port_two_pin_i, port_one_pin_i};
		end
	end
endmodule : ppm_ext_memory

//--- sim/test_ppm_port_power.sv
// Purpose: Self-checking bench for the port and power mode controller.
// Assumes: Inputs change on the falling clock edge.
// Notes:   The sync stages on pins cost a few cycles; waits allow for them.
`timescale 1ns/1ps
module test_ppm_port_power
	import ppm_pkg::*;
;
	// Starts low before any process runs, so the first negedge is a real one
	logic        clk = 1'b0;
	logic        rst, wr_en, wake, ale_p, psen_p, fetch, xfetch, lo_en, acc_sel_n, sel_in;
	logic [7:0]  addr, wdata, rdata, pz, scan, pin1, pin1_oe;
	logic [14:0] faddr, mem_addr;
	logic [6:0]  pin2, pin2_oe;
	logic        core_en, per_en, osc_en, xmem, susp, ale, psen_n, sel, sel_oe, adb_oe, hdb_oe;
	logic [4:0]  od_oe, od_pin;
	int          err_count, checks_done;

	ppm_port_power u_ppm_port_power (
		.ref_clk_i(clk), .reset_i(rst), .sfr_write_i(wr_en), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
		.sfr_rdata_o(rdata), .fetch_addr_i(faddr), .fetch_active_i(fetch), .addr_latch_pulse_i(ale_p),
		.prog_store_pulse_i(psen_p), .ext_fetch_i(xfetch), .wake_interrupt_i(wake), .port_zero_i(pz),
		.core_clk_enable_o(core_en), .periph_clk_enable_o(per_en), .osc_enable_o(osc_en),
		.ext_program_mem_o(xmem), .conversion_suspect_o(susp), .scan_drive_o(scan),
		.low_addr_out_enable_i(lo_en), .ext_access_select_n_i(acc_sel_n), .port_one_pin_o(pin1),
		.port_one_oe_o(pin1_oe), .port_two_pin_o(pin2), .port_two_oe_o(pin2_oe), .addr_latch_strobe_o(ale),
		.prog_store_strobe_n_o(psen_n), .ext_mem_select_n_i(sel_in), .ext_mem_select_n_o(sel),
		.ext_mem_select_n_oe_o(sel_oe), .muxed_addr_data_bus_oe_o(adb_oe), .host_data_bus_oe_o(hdb_oe),
		.open_drain_oe_o(od_oe), .open_drain_pin_o(od_pin));

	ppm_ext_memory u_ppm_ext_memory (
		.ref_clk_i(clk), .addr_latch_strobe_i(ale), .port_one_pin_i(pin1), .port_two_pin_i(pin2),
		.select_n_i(sel), .select_n_oe_i(sel_oe), .select_n_o(sel_in), .latched_addr_o(mem_addr));

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		tick(1);
		wr_en = 1'b0;
		// Idle edge so a following write never re-raises the strobe in the same step
		tick(1);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		addr = a;
		tick(1);
		d = rdata;
	endtask : rd

	// Pin is held through reset so the sync stages settle before release
	task automatic do_reset(input logic pin);
		acc_sel_n = pin;
		rst = 1'b1;
		tick(5);
		rst = 1'b0;
		tick(2);
	endtask : do_reset

	task automatic end_sim;
		$display("checks_done=%0d err_count=%0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		logic [7:0] d;
		check({pin1, pin1_oe}, 16'hff00);
		check({1'b0, pin2, 1'b0, pin2_oe}, 16'h7f00);
		check({adb_oe, hdb_oe, od_oe, od_pin}, 16'h0000);
		check(xmem, 1'b0);
		rd(8'h87, d);
		check(d, 8'h00);
		rd(8'h55, d);
		check(d, 8'h00);
		pz = 8'h3c;
		tick(1);
		check(scan, 8'h3c);
	endtask : t_reset

	task automatic t_strong;
		wr(8'h90, 8'h00);
		tick(1);
		check({pin1, pin1_oe}, 16'h00ff);
		wr(8'h90, 8'hff);
		check({pin1, pin1_oe}, 16'hffff);
		tick(1);
		check({pin1, pin1_oe}, 16'hffff);
		tick(1);
		check({pin1, pin1_oe}, 16'hff00);
	endtask : t_strong

	task automatic t_addr;
		fetch = 1'b1;
		xfetch = 1'b1;
		faddr = 15'h2a5c;
		lo_en = 1'b1;
		tick(4);
		check(pin1, 8'h5c);
		check(pin2, 7'h7f);
		check({adb_oe, sel, sel_oe}, 3'h5);
		wr(8'hb0, 8'h01);
		tick(2);
		check(pin2, 7'h2a);
		ale_p = 1'b1;
		tick(1);
		ale_p = 1'b0;
		tick(3);
		check(mem_addr, 15'h2a5c);
		lo_en = 1'b0;
		tick(4);
		check(pin1, 8'hff);
		fetch = 1'b0;
		xfetch = 1'b0;
		wr(8'hb0, 8'h00);
	endtask : t_addr

	task automatic t_idle;
		logic [7:0] d;
		// Store strobe active and address strobe low before idle, so the forced-high check can trip
		{psen_p, xfetch} = 2'b11;
		wr(8'h90, 8'ha5);
		check(psen_n, 1'b0);
		wr(8'h87, 8'h01);
		tick(2);
		check({core_en, per_en, ale, psen_n}, 4'h7);
		check(susp, 1'b1);
		wr(8'h90, 8'h3c);
		tick(2);
		check(pin1, 8'ha5);
		rd(8'h90, d);
		check(d, 8'ha5);
		wake = 1'b1;
		tick(1);
		wake = 1'b0;
		tick(2);
		check(core_en, 1'b1);
		rd(8'h87, d);
		check(d[0], 1'b0);
		{psen_p, xfetch} = 2'b00;
	endtask : t_idle

	task automatic t_pdown(input logic [7:0] cfg);
		wr(8'hb0, cfg);
		wr(8'ha0, 8'h00);
		ale_p = 1'b1;
		wr(8'h87, 8'h02);
		tick(2);
		check({osc_en, per_en, core_en, ale, psen_n}, 5'h00);
		check(sel, cfg[3] ? 1'b0 : 1'b1);
		wake = 1'b1;
		tick(2);
		wake = 1'b0;
		tick(2);
		check(osc_en, 1'b0);
		ale_p = 1'b0;
		do_reset(1'b1);
		check({osc_en, core_en}, 2'h3);
	endtask : t_pdown

	task automatic t_acc_low;
		do_reset(1'b0);
		check(xmem, 1'b1);
		fetch = 1'b1;
		faddr = 15'h1b00;
		tick(4);
		check(pin2, 7'h1b);
		fetch = 1'b0;
	endtask : t_acc_low

	// ==========================================================
	// Clock, watchdog and main sequence
	initial begin
		forever #5 clk = ~clk;
	end

	initial begin
		#200000;
		err_count++;
		end_sim();
	end

	initial begin
		err_count = 0;
		checks_done = 0;
		{wr_en, wake, ale_p, psen_p, fetch, xfetch, lo_en} = '0;
		{addr, wdata, pz, faddr} = '0;
		do_reset(1'b1);
		t_reset();
		t_strong();
		t_addr();
		t_idle();
		t_pdown(8'h00);
		t_pdown(8'h08);
		t_acc_low();
		end_sim();
	end
endmodule : test_ppm_port_power
